// >>> common/lpddc_if.sv
// command/address link between controller and memory device
`timescale 1ns/1ps
`default_nettype none
interface lpddc_if;
	import lpddc_pkg::*;
	// ========================================
	// pins, both halves of the double rate bus
	logic            cs_n;
	logic            cke;
	logic [CA_W-1:0] ca_rise;
	logic [CA_W-1:0] ca_fall;

	modport host (output cs_n, output cke, output ca_rise, output ca_fall);
	modport dev  (input cs_n, input cke, input ca_rise, input ca_fall);
endinterface
`default_nettype wire

// >>> common/lpddc_pkg.sv
// shared constants and types of the command/address decoder pair
package lpddc_pkg;
	// ========================================
	// bus geometry
	localparam int CA_W   = 10;
	localparam int BANK_W = 3;
	localparam int ROW_W  = 15;
	localparam int COL_W  = 12;
	localparam int MA_W   = 8;
	localparam int OP_W   = 8;

	// ========================================
	// field positions on the rising half
	localparam int R_MA_LSB  = 4;   // mode_reg_address low six bits
	localparam int R_ROW_LSB = 2;   // row bits 12..8
	localparam int R_COL_LSB = 5;   // column bits 2..1
	localparam int R_AB_BIT  = 4;   // all_banks_flag
	localparam int R_BA_LSB  = 7;   // bank address
	// field positions on the falling half
	localparam int F_MA_LSB  = 0;   // mode_reg_address high two bits
	localparam int F_OP_LSB  = 2;   // operand_bits
	localparam int F_AP_BIT  = 0;   // auto_precharge_flag
	localparam int F_COL_LSB = 1;   // column bits 11..3
	localparam int F_RHI_LSB = 8;   // row bits 14..13

	// ========================================
	// mode register addresses
	localparam logic [MA_W-1:0] MA_DEVICE_RESET_TRIGGER = 8'h3F;
	localparam logic [MA_W-1:0] MA_UNUSED_BF            = 8'hBF;
	localparam logic [MA_W-1:0] MA_UNUSED_FF            = 8'hFF;
	localparam logic [MA_W-1:0] MA_RESERVED_LO          = 8'h40;

	// ========================================
	// reset values and timing
	localparam logic [CA_W-1:0] CA_IDLE = 10'h000;
	localparam int NUM_BANKS_DEF = 8;
	localparam int CLK_PERIOD_NS = 8;
	localparam int TXP_NS        = 24;
	localparam int TXP_CYC_DEF   = (TXP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BURST_LEN     = 8;
	localparam int BURST_CYC_DEF = BURST_LEN / 2;

	// ========================================
	// decoded commands and power states
	typedef enum logic [3:0] {
		CMD_NOP, CMD_MRW, CMD_MRR, CMD_REFPB, CMD_REFAB, CMD_ACT, CMD_WR,
		CMD_RD, CMD_PRE, CMD_BST, CMD_PDE, CMD_SRE, CMD_DPDE, CMD_PDX
	} lpddc_cmd_t;

	typedef enum logic [2:0] {
		PW_RUN, PW_APD, PW_IPD, PW_SREF, PW_DPD
	} lpddc_pwr_t;

	// addresses at or above 040 are reserved, vendor or unused
	function automatic logic lpddc_ma_forbidden(input logic [MA_W-1:0] a);
		return a >= MA_RESERVED_LO;
	endfunction
endpackage

// >>> rtl/lpddc_dev.sv
// memory-side command/address decoder with bank and power tracking
`timescale 1ns/1ps
`default_nettype none
module lpddc_dev
	import lpddc_pkg::*;
#(
	parameter int NUM_BANKS = NUM_BANKS_DEF,
	parameter int BURST_CYC = BURST_CYC_DEF
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              srst,
	// link to the controller
	lpddc_if.dev                   bus,
	// decoded command
	output logic                   cmd_valid,
	output lpddc_cmd_t             cmd_code,
	output logic [BANK_W-1:0]      cmd_bank,
	output logic [ROW_W-1:0]       cmd_row,
	output logic [COL_W-1:0]       cmd_col,
	output logic [MA_W-1:0]        mode_reg_address,
	output logic [OP_W-1:0]        operand_bits,
	output logic                   auto_precharge_flag,
	output logic                   all_banks_flag,
	// device state
	output logic                   dev_reset,
	output logic                   ap_done,
	output logic                   illegal,
	output lpddc_pwr_t             pwr_state,
	output logic [NUM_BANKS-1:0]   banks_open,
	output logic                   wake
);
	// ========================================
	// registers
	logic                 cke_prev_r;
	lpddc_pwr_t           pwr_r;
	logic [NUM_BANKS-1:0] open_r;
	logic                 ill_r;
	logic [BANK_W-1:0]    ap_bank_r;
	logic [7:0]           ap_cnt_r;
	logic                 ap_done_r;
	logic                 valid_r;
	lpddc_cmd_t           code_r;
	logic [CA_W-1:0]      rise_r;
	logic [CA_W-1:0]      fall_r;
	logic                 rst_r;

	// decode nets
	lpddc_cmd_t           cmd_nxt;
	logic                 bad_nxt;
	logic [3:0]           op4;
	logic [MA_W-1:0]      ma_now;
	logic [BANK_W-1:0]    ba_now;
	logic                 any_open;

	assign op4      = {bus.ca_rise[0], bus.ca_rise[1], bus.ca_rise[2], bus.ca_rise[3]};
	assign ma_now   = {bus.ca_fall[F_MA_LSB +: 2], bus.ca_rise[R_MA_LSB +: 6]};
	assign ba_now   = bus.ca_rise[R_BA_LSB +: BANK_W];
	assign any_open = |open_r;

	// ========================================
	// command identification from cs_n, cke and op4
	always_comb begin
		cmd_nxt = CMD_NOP;
		bad_nxt = 1'b0;
		if (cke_prev_r && bus.cke) begin
			if (!bus.cs_n) begin
				casez (op4)
					4'b0000: cmd_nxt = CMD_MRW;
					4'b0001: cmd_nxt = CMD_MRR;
					4'b0010: cmd_nxt = CMD_REFPB;
					4'b0011: cmd_nxt = CMD_REFAB;
					4'b01??: cmd_nxt = CMD_ACT;
					4'b100?: cmd_nxt = CMD_WR;
					4'b101?: cmd_nxt = CMD_RD;
					4'b1101: cmd_nxt = CMD_PRE;
					4'b1100: cmd_nxt = CMD_BST;
					default: cmd_nxt = CMD_NOP;
				endcase
			end
			if (pwr_r != PW_RUN)
				bad_nxt = !bus.cs_n;
		end else if (cke_prev_r && !bus.cke) begin
			if (bus.cs_n) begin
				cmd_nxt = CMD_PDE;
			end else begin
				casez (op4[3:1])
					3'b001:  cmd_nxt = CMD_SRE;
					3'b110:  cmd_nxt = CMD_DPDE;
					default: bad_nxt = 1'b1;
				endcase
			end
		end else if (!cke_prev_r && bus.cke) begin
			cmd_nxt = CMD_PDX;
			bad_nxt = !bus.cs_n;
		end
		// commands that are defined but not allowed here
		case (cmd_nxt)
			CMD_REFPB: if (NUM_BANKS != 8) bad_nxt = 1'b1;
			CMD_MRR:   if (ma_now == MA_DEVICE_RESET_TRIGGER) bad_nxt = 1'b1;
			CMD_MRW:   if (lpddc_ma_forbidden(ma_now)) bad_nxt = 1'b1;
			CMD_SRE, CMD_DPDE: if (any_open) bad_nxt = 1'b1;
			default: ;
		endcase
	end

	// ========================================
	// cke history, sampled at rise only
	always_ff @(posedge ref_clk) begin
		if (srst)
			cke_prev_r <= 1'b1;
		else
			cke_prev_r <= bus.cke;
	end

	// ========================================
	// both bus halves captured with the command
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			valid_r <= 1'b0;
			code_r  <= CMD_NOP;
			rise_r  <= CA_IDLE;
			fall_r  <= CA_IDLE;
		end else begin
			valid_r <= (cmd_nxt != CMD_NOP) && !bad_nxt;
			code_r  <= cmd_nxt;
			rise_r  <= bus.cs_n ? CA_IDLE : bus.ca_rise;
			fall_r  <= bus.cs_n ? CA_IDLE : bus.ca_fall;
		end
	end

	// ========================================
	// sticky flag for undefined events, cleared only by reset
	always_ff @(posedge ref_clk) begin
		if (srst)
			ill_r <= 1'b0;
		else if (bad_nxt)
			ill_r <= 1'b1;
	end

	// ========================================
	// device reset request from mode write
	always_ff @(posedge ref_clk) begin
		if (srst)
			rst_r <= 1'b0;
		else
			rst_r <= !bad_nxt && cmd_nxt == CMD_MRW && ma_now == MA_DEVICE_RESET_TRIGGER;
	end

	// ========================================
	// power state; exit follows cke directly
	assign wake = (pwr_r != PW_RUN) && bus.cke;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pwr_r <= PW_RUN;
		end else if (wake) begin
			pwr_r <= PW_RUN;
		end else if (!bad_nxt) begin
			case (cmd_nxt)
				CMD_PDE:  pwr_r <= any_open ? PW_APD : PW_IPD;
				CMD_SRE:  pwr_r <= PW_SREF;
				CMD_DPDE: pwr_r <= PW_DPD;
				default:  pwr_r <= pwr_r;
			endcase
		end
	end

	// ========================================
	// open banks: activate, precharge, auto precharge
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			open_r <= '0;
		end else if (wake && pwr_r == PW_DPD) begin
			open_r <= '0; // deep exit loses all content
		end else begin
			if (ap_cnt_r == 8'h01)
				open_r[ap_bank_r] <= 1'b0;
			if (!bad_nxt && cmd_nxt == CMD_ACT)
				open_r[ba_now] <= 1'b1;
			if (!bad_nxt && cmd_nxt == CMD_PRE) begin
				if (bus.ca_rise[R_AB_BIT])
					open_r <= '0;
				else
					open_r[ba_now] <= 1'b0;
			end
		end
	end

	// ========================================
	// auto precharge timer, one pending bank
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ap_cnt_r  <= 8'h00;
			ap_bank_r <= '0;
			ap_done_r <= 1'b0;
		end else begin
			ap_done_r <= ap_cnt_r == 8'h01;
			if (!bad_nxt && (cmd_nxt == CMD_RD || cmd_nxt == CMD_WR)
			    && bus.ca_fall[F_AP_BIT]) begin
				ap_cnt_r  <= 8'(BURST_CYC);
				ap_bank_r <= ba_now;
			end else if (ap_cnt_r != 8'h00) begin
				ap_cnt_r <= ap_cnt_r - 8'h01;
			end
		end
	end

	// ========================================
	// field extraction from the captured halves
	assign cmd_valid           = valid_r;
	assign cmd_code            = code_r;
	assign cmd_bank            = rise_r[R_BA_LSB +: BANK_W];
	assign cmd_row             = {fall_r[F_RHI_LSB +: 2], rise_r[R_ROW_LSB +: 5],
	                              fall_r[7:0]};
	assign cmd_col             = {fall_r[F_COL_LSB +: 9], rise_r[R_COL_LSB +: 2], 1'b0};
	assign mode_reg_address    = {fall_r[F_MA_LSB +: 2], rise_r[R_MA_LSB +: 6]};
	assign operand_bits        = fall_r[F_OP_LSB +: OP_W];
	assign auto_precharge_flag = fall_r[F_AP_BIT];
	assign all_banks_flag      = rise_r[R_AB_BIT];
	assign dev_reset           = rst_r;
	assign ap_done             = ap_done_r;
	assign illegal             = ill_r;
	assign pwr_state           = pwr_r;
	assign banks_open          = open_r;
endmodule
`default_nettype wire

// >>> rtl/lpddc_host.sv
// controller-side command encoder driving the command/address link
`timescale 1ns/1ps
`default_nettype none
module lpddc_host
	import lpddc_pkg::*;
#(
	parameter int TXP_CYC = TXP_CYC_DEF
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              srst,
	// link to the device
	lpddc_if.host                  bus,
	// command request
	input  wire logic              req_valid,
	output logic                   req_ready,
	input  wire lpddc_cmd_t        req_cmd,
	input  wire logic [BANK_W-1:0] req_bank,
	input  wire logic [ROW_W-1:0]  req_row,
	input  wire logic [COL_W-1:0]  req_col,
	input  wire logic [MA_W-1:0]   req_ma,
	input  wire logic [OP_W-1:0]   req_op,
	input  wire logic              req_ap,
	input  wire logic              req_ab,
	// refusal
	output logic                   req_refused
);
	// ========================================
	// registers and nets
	logic            cs_n_r;
	logic            cke_r;
	logic [CA_W-1:0] rise_r;
	logic [CA_W-1:0] fall_r;
	logic [7:0]      xp_cnt_r;
	logic            ref_r;
	logic            cs_nxt;
	logic            cke_nxt;
	logic [CA_W-1:0] rise_nxt;
	logic [CA_W-1:0] fall_nxt;
	logic            bad;
	logic            take;

	// ========================================
	// hold off after power-down exit
	assign req_ready = xp_cnt_r == 8'h00;
	assign bad = (!cke_r != (req_cmd == CMD_PDX))
	           || (req_cmd == CMD_MRW && lpddc_ma_forbidden(req_ma))
	           || (req_cmd == CMD_MRR && req_ma == MA_DEVICE_RESET_TRIGGER)
	           || (req_cmd == CMD_REFPB && NUM_BANKS_DEF != 8);
	assign take = req_valid && req_ready && !bad;

	// ========================================
	// encoding; unused positions driven low
	always_comb begin
		cs_nxt   = 1'b1;
		cke_nxt  = cke_r;
		rise_nxt = CA_IDLE;
		fall_nxt = CA_IDLE;
		if (take) begin
			case (req_cmd)
				CMD_MRW, CMD_MRR: begin
					cs_nxt = 1'b0;
					rise_nxt[3] = req_cmd == CMD_MRR;
					rise_nxt[R_MA_LSB +: 6] = req_ma[5:0];
					fall_nxt[F_MA_LSB +: 2] = req_ma[7:6];
					if (req_cmd == CMD_MRW)
						fall_nxt[F_OP_LSB +: OP_W] = req_op;
				end
				CMD_REFPB, CMD_REFAB: begin
					cs_nxt = 1'b0;
					rise_nxt[2] = 1'b1;
					rise_nxt[3] = req_cmd == CMD_REFAB;
				end
				CMD_ACT: begin
					cs_nxt = 1'b0;
					rise_nxt[1] = 1'b1;
					rise_nxt[R_ROW_LSB +: 5] = req_row[12:8];
					rise_nxt[R_BA_LSB +: BANK_W] = req_bank;
					fall_nxt[7:0] = req_row[7:0];
					fall_nxt[F_RHI_LSB +: 2] = req_row[14:13];
				end
				CMD_WR, CMD_RD: begin
					cs_nxt = 1'b0;
					rise_nxt[0] = 1'b1;
					rise_nxt[2] = req_cmd == CMD_RD;
					rise_nxt[R_COL_LSB +: 2] = req_col[2:1];
					rise_nxt[R_BA_LSB +: BANK_W] = req_bank;
					fall_nxt[F_AP_BIT] = req_ap;
					fall_nxt[F_COL_LSB +: 9] = req_col[11:3];
				end
				CMD_PRE, CMD_BST: begin
					cs_nxt = 1'b0;
					rise_nxt[1:0] = 2'b11;
					if (req_cmd == CMD_PRE) begin
						rise_nxt[3] = 1'b1;
						rise_nxt[R_AB_BIT] = req_ab;
						rise_nxt[R_BA_LSB +: BANK_W] = req_bank;
					end
				end
				CMD_PDE: cke_nxt = 1'b0;
				CMD_SRE: begin
					cs_nxt = 1'b0;
					cke_nxt = 1'b0;
					rise_nxt[2] = 1'b1;
				end
				CMD_DPDE: begin
					cs_nxt = 1'b0;
					cke_nxt = 1'b0;
					rise_nxt[1:0] = 2'b11;
				end
				CMD_PDX: cke_nxt = 1'b1;
				default: ;
			endcase
		end
	end

	// ========================================
	// registered pins
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cs_n_r <= 1'b1;
			cke_r  <= 1'b1;
			rise_r <= CA_IDLE;
			fall_r <= CA_IDLE;
		end else begin
			cs_n_r <= cs_nxt;
			cke_r  <= cke_nxt;
			rise_r <= rise_nxt;
			fall_r <= fall_nxt;
		end
	end

	// ========================================
	// exit timer and refusal pulse
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			xp_cnt_r <= 8'h00;
			ref_r    <= 1'b0;
		end else begin
			ref_r <= req_valid && req_ready && bad;
			if (take && req_cmd == CMD_PDX)
				xp_cnt_r <= 8'(TXP_CYC);
			else if (xp_cnt_r != 8'h00)
				xp_cnt_r <= xp_cnt_r - 8'h01;
		end
	end

	assign bus.cs_n    = cs_n_r;
	assign bus.cke     = cke_r;
	assign bus.ca_rise = rise_r;
	assign bus.ca_fall = fall_r;
	assign req_refused = ref_r;
endmodule
`default_nettype wire

// >>> testbench/lpddc_monitor.sv
// concurrent checks on the command/address link and the decoder answers
`timescale 1ns/1ps
`default_nettype none
module lpddc_monitor
	import lpddc_pkg::*;
#(
	parameter int NUM_BANKS = NUM_BANKS_DEF
) (
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 srst,
	// link pins
	input  wire logic                 cs_n,
	input  wire logic                 cke,
	input  wire logic [CA_W-1:0]      ca_rise,
	input  wire logic [CA_W-1:0]      ca_fall,
	// decoder answers
	input  wire logic                 cmd_valid,
	input  wire lpddc_cmd_t           cmd_code,
	input  wire logic [BANK_W-1:0]    cmd_bank,
	input  wire logic                 dev_reset,
	input  wire logic                 illegal,
	input  wire lpddc_pwr_t           pwr_state,
	input  wire logic [NUM_BANKS-1:0] banks_open,
	input  wire logic                 wake
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	// ========================================
	// command shapes on the rising half
	sequence s_live;
		!cs_n && cke && $past(cke) && pwr_state == PW_RUN;
	endsequence
	sequence s_act;
		s_live ##0 ca_rise[1:0] == 2'b10;
	endsequence
	sequence s_mrw_rst;
		s_live ##0 ca_rise == {6'h3F, 4'h0} && ca_fall[1:0] == 2'b00;
	endsequence
	sequence s_pre_all;
		s_live ##0 ca_rise[4:0] == 5'b11011;
	endsequence
	sequence s_sre_busy;
		$fell(cke) && !cs_n && ca_rise[2:0] == 3'b100 && banks_open != '0;
	endsequence

	// ========================================
	// checks
	a_act_decode: assert property (s_act |=> cmd_valid && cmd_code == CMD_ACT
		&& cmd_bank == $past(ca_rise[9:7]))
		else $error("activate not decoded with its bank");
	a_nop_ignored: assert property (cs_n && cke && $past(cke) |=> !cmd_valid)
		else $error("deselected cycle produced a command");
	a_reset_trigger: assert property (s_mrw_rst |=> dev_reset && cmd_valid)
		else $error("mode write to reset address gave no reset");
	a_pre_all: assert property (s_pre_all |=> banks_open == '0)
		else $error("precharge of all banks left a bank open");
	a_pd_entry: assert property ($fell(cke) && cs_n && pwr_state == PW_RUN
		|=> pwr_state == ($past(banks_open) != '0 ? PW_APD : PW_IPD))
		else $error("power-down entry went to wrong state");
	a_sre_busy: assert property (s_sre_busy |=> illegal && !cmd_valid)
		else $error("self-refresh with open bank not flagged");
	a_wake_async: assert property ($rose(cke) && pwr_state != PW_RUN
		|-> wake ##1 pwr_state == PW_RUN)
		else $error("exit not seen while clock enable high");
	a_illegal_held: assert property (illegal |=> illegal [*3])
		else $error("illegal flag dropped without reset");
	a_exit_quiet: assert property ($rose(cke) |-> cs_n [*4])
		else $error("command issued inside exit time");
	a_idle_levels: assert property (cs_n |-> ca_rise == '0 && ca_fall == '0)
		else $error("bus not at defined level while deselected");
endmodule
`default_nettype wire

// >>> testbench/lpddc_tb_top.sv
// self-checking bench joining the controller and device ends
`timescale 1ns/1ps
`default_nettype none
module lpddc_tb_top;
	import lpddc_pkg::*;
	// ========================================
	// signals
	logic              ref_clk;
	logic              srst;
	logic              req_valid;
	logic              req_ready;
	lpddc_cmd_t        req_cmd;
	logic [BANK_W-1:0] req_bank;
	logic [ROW_W-1:0]  req_row;
	logic [COL_W-1:0]  req_col;
	logic [MA_W-1:0]   req_ma;
	logic [OP_W-1:0]   req_op;
	logic              req_ap;
	logic              req_ab;
	logic              req_refused;
	logic              cmd_valid;
	lpddc_cmd_t        cmd_code;
	logic [BANK_W-1:0] cmd_bank;
	logic [ROW_W-1:0]  cmd_row;
	logic [COL_W-1:0]  cmd_col;
	logic [MA_W-1:0]   mode_reg_address;
	logic [OP_W-1:0]   operand_bits;
	logic              auto_precharge_flag;
	logic              all_banks_flag;
	logic              dev_reset;
	logic              ap_done;
	logic              illegal;
	lpddc_pwr_t        pwr_state;
	logic [7:0]        banks_open;
	logic              wake;
	int                err_count;
	int                checks;

	// ========================================
	// the two ends and the checker
	lpddc_if bus ();
	lpddc_host i_lpddc_host (.ref_clk(ref_clk), .srst(srst), .bus(bus.host),
		.req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
		.req_bank(req_bank), .req_row(req_row), .req_col(req_col), .req_ma(req_ma),
		.req_op(req_op), .req_ap(req_ap), .req_ab(req_ab), .req_refused(req_refused));
	lpddc_dev i_lpddc_dev (.ref_clk(ref_clk), .srst(srst), .bus(bus.dev),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank), .cmd_row(cmd_row),
		.cmd_col(cmd_col), .mode_reg_address(mode_reg_address), .operand_bits(operand_bits),
		.auto_precharge_flag(auto_precharge_flag), .all_banks_flag(all_banks_flag),
		.dev_reset(dev_reset), .ap_done(ap_done), .illegal(illegal), .pwr_state(pwr_state),
		.banks_open(banks_open), .wake(wake));
	lpddc_monitor i_lpddc_monitor (.ref_clk(ref_clk), .srst(srst), .cs_n(bus.cs_n),
		.cke(bus.cke), .ca_rise(bus.ca_rise), .ca_fall(bus.ca_fall), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_bank(cmd_bank), .dev_reset(dev_reset), .illegal(illegal),
		.pwr_state(pwr_state), .banks_open(banks_open), .wake(wake));

	// ========================================
	// helpers
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask
	task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
		cmp(got, exp, "link pin");
	endtask
	task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
		cmp(got, exp, "decoder output");
	endtask
	task automatic step();
		@(posedge ref_clk);
		#1;
	endtask
	// one request, held until the take edge; returns with pins visible
	task automatic send(input lpddc_cmd_t c, input logic [2:0] b, input logic [14:0] v,
			input logic [7:0] m, input logic [7:0] o, input logic [1:0] fl);
		while (req_ready !== 1'b1) step();
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_cmd <= c;
		req_bank <= b;
		req_row <= v;
		req_col <= v[11:0];
		req_ma <= m;
		req_op <= o;
		req_ap <= fl[1];
		req_ab <= fl[0];
		@(posedge ref_clk);
		req_valid <= 1'b0;
		#1;
	endtask

	// ========================================
	// scenarios
	task automatic t_act();
		send(CMD_ACT, 3'h5, 15'h5A3C, 8'h00, 8'h00, 2'b00);
		chk_pin(bus.cs_n, 1'b0);
		chk_pin(bus.ca_rise, {3'h5, 5'h1A, 2'b10});
		chk_pin(bus.ca_fall, {2'b10, 8'h3C});
		step();
		chk_out(cmd_valid, 1'b1);
		chk_out(cmd_code, CMD_ACT);
		chk_out(cmd_bank, 3'h5);
		chk_out(cmd_row, 15'h5A3C);
		chk_out(banks_open, 8'h20);
		step();
		chk_out(cmd_valid, 1'b0);
		$display("test act done");
	endtask
	task automatic t_col(input lpddc_cmd_t c, input logic ap);
		int i;
		send(c, 3'h5, 15'h0ABF, 8'h00, 8'h00, {ap, 1'b0});
		chk_pin({bus.ca_rise[9:5], bus.ca_rise[2:0]}, {5'h17, (c == CMD_RD) ? 3'b101 : 3'b001});
		chk_pin(bus.ca_fall, {9'h157, ap});
		step();
		chk_out(cmd_code, c);
		chk_out(cmd_col, 12'hABE);
		chk_out(auto_precharge_flag, ap);
		for (i = 0; ap && i < 8 && ap_done !== 1'b1; i++) step();
		if (ap) begin
			chk_out(32'(i), BURST_CYC_DEF);
			chk_out(banks_open[5], 1'b0);
		end
		$display("test column access done");
	endtask
	task automatic t_pre();
		send(CMD_ACT, 3'h1, 15'h0001, 8'h00, 8'h00, 2'b00);
		send(CMD_ACT, 3'h6, 15'h0002, 8'h00, 8'h00, 2'b00);
		send(CMD_PRE, 3'h1, 15'h0000, 8'h00, 8'h00, 2'b00);
		chk_pin({bus.ca_rise[9:7], bus.ca_rise[4:0]}, {3'h1, 5'b01011});
		step();
		chk_out(banks_open, 8'h40);
		send(CMD_PRE, 3'h0, 15'h0000, 8'h00, 8'h00, 2'b01);
		step();
		chk_out(all_banks_flag, 1'b1);
		chk_out(banks_open, 8'h00);
		$display("test precharge done");
	endtask
	task automatic t_codes();
		lpddc_cmd_t cl[3] = '{CMD_REFPB, CMD_REFAB, CMD_BST};
		logic [3:0] pl[3] = '{4'b0100, 4'b1100, 4'b0011};
		for (int i = 0; i < 3; i++) begin
			send(cl[i], 3'h2, 15'h0000, 8'h00, 8'h00, 2'b00);
			chk_pin(bus.ca_rise[3:0], pl[i]);
			step();
			chk_out({cmd_valid, cmd_code}, {1'b1, cl[i]});
		end
		$display("test command codes done");
	endtask
	task automatic mr(input lpddc_cmd_t c, input logic [7:0] m, input logic [7:0] o);
		send(c, 3'h0, 15'h0000, m, o, 2'b00);
		chk_pin(bus.ca_rise, {m[5:0], (c == CMD_MRR) ? 4'b1000 : 4'b0000});
		chk_pin(bus.ca_fall[1:0], m[7:6]);
		if (c == CMD_MRW) chk_pin(bus.ca_fall[9:2], o);
		step();
		chk_out({cmd_code, mode_reg_address}, {c, m});
		if (c == CMD_MRW) chk_out(operand_bits, o);
		chk_out(dev_reset, c == CMD_MRW && m == 8'h3F);
	endtask
	task automatic t_mode();
		logic [7:0] rm[7] = '{8'h40, 8'h7E, 8'h80, 8'hBF, 8'hC0, 8'hFF, 8'h3F};
		mr(CMD_MRW, 8'h2A, 8'hC5);
		mr(CMD_MRR, 8'hC5, 8'h00);
		mr(CMD_MRW, 8'h3F, 8'h5A);
		for (int i = 0; i < 7; i++) begin
			send((i == 6) ? CMD_MRR : CMD_MRW, 3'h0, 15'h0000, rm[i], 8'hA5, 2'b00);
			chk_pin({req_refused, bus.cs_n}, 2'b11);
		end
		$display("test mode registers done");
	endtask
	task automatic t_pd();
		for (int k = 0; k < 2; k++) begin
			if (k == 0) send(CMD_ACT, 3'h3, 15'h0003, 8'h00, 8'h00, 2'b00);
			send(CMD_PDE, 3'h0, 15'h0000, 8'h00, 8'h00, 2'b00);
			chk_pin({bus.cke, bus.cs_n}, 2'b01);
			step();
			chk_out(pwr_state, (k == 0) ? PW_APD : PW_IPD);
			send(CMD_ACT, 3'h4, 15'h0000, 8'h00, 8'h00, 2'b00);
			chk_pin({req_refused, bus.cs_n}, 2'b11);
			send(CMD_PDX, 3'h0, 15'h0000, 8'h00, 8'h00, 2'b00);
			chk_out(wake, 1'b1);
			step();
			chk_out({req_ready, pwr_state}, {1'b0, PW_RUN});
			if (k == 0) send(CMD_PRE, 3'h0, 15'h0000, 8'h00, 8'h00, 2'b01);
		end
		$display("test power-down done");
	endtask
	task automatic t_sleep();
		lpddc_cmd_t cl[2] = '{CMD_SRE, CMD_DPDE};
		for (int i = 0; i < 2; i++) begin
			send(cl[i], 3'h0, 15'h0000, 8'h00, 8'h00, 2'b00);
			chk_pin({bus.cke, bus.cs_n, bus.ca_rise[2:0]}, {2'b00, (i == 0) ? 3'b100 : 3'b011});
			step();
			chk_out(pwr_state, (i == 0) ? PW_SREF : PW_DPD);
			send(CMD_PDX, 3'h0, 15'h0000, 8'h00, 8'h00, 2'b00);
			chk_out(wake, 1'b1);
			step();
			chk_out(pwr_state, PW_RUN);
		end
		$display("test self-refresh and deep power-down done");
	endtask
	task automatic t_bad();
		send(CMD_ACT, 3'h0, 15'h0000, 8'h00, 8'h00, 2'b00);
		send(CMD_SRE, 3'h0, 15'h0000, 8'h00, 8'h00, 2'b00);
		step();
		chk_out({illegal, cmd_valid}, 2'b10);
		repeat (3) step();
		chk_out(illegal, 1'b1);
		$display("test illegal entry done");
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ========================================
	// clock, watchdog and main sequence
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		err_count++;
		end_sim();
	end
	initial begin
		srst = 1'b1;
		req_valid = 1'b0;
		req_cmd = CMD_NOP;
		{req_bank, req_row, req_col, req_ma, req_op, req_ap, req_ab} = '0;
		err_count = 0;
		checks = 0;
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		#1;
		t_act();
		t_col(CMD_WR, 1'b0);
		t_col(CMD_RD, 1'b1);
		t_pre();
		t_codes();
		t_mode();
		t_pd();
		t_sleep();
		t_bad();
		end_sim();
	end
endmodule
`default_nettype wire
